/* scd_pkg.sv */
// Package: register map, field layout and codes of the clock select block
package scd_pkg;
  localparam logic [7:0] CLK_SELECT_ADDR = 8'ha9;
  localparam logic [7:0] OSC_CONTROL_ADDR = 8'hb2;
  localparam int unsigned RDY_BIT = 7;
  localparam int unsigned DIV_LSB = 4;
  localparam int unsigned UNUSED_BIT = 3;
  localparam int unsigned SEL_LSB = 0;
  localparam int unsigned EN_BIT = 7;
  localparam int unsigned FRDY_BIT = 6;
  localparam logic [2:0] DIV_RESET = 3'h1;
  localparam logic [2:0] APPLIED_DIV_RESET = 3'h0;
  localparam logic [2:0] SEL_RESET = 3'h2;
  localparam logic EN_RESET = 1'b0;
  localparam logic [5:0] OSC_RSVD_RESET = 6'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [2:0] SRC_PRECISION = 3'h0;
  localparam logic [2:0] SRC_EXTERNAL = 3'h1;
  localparam logic [2:0] SRC_LP_DIV8 = 3'h2;
  localparam logic [2:0] SRC_RTC = 3'h3;
  localparam logic [2:0] SRC_LOW_POWER = 3'h4;
  localparam int unsigned NUM_SRC = 5;
  localparam int unsigned MAX_DIV_SRC_CYCLES = 128;
  localparam logic [8:0] MAX_DIV_SRC_EDGES = 9'(2 * MAX_DIV_SRC_CYCLES);

  function automatic logic sel_valid(input logic [2:0] s);
    return s <= SRC_LOW_POWER;
  endfunction : sel_valid

  // Source edges per output half period, minus one
  function automatic logic [6:0] half_term(input logic [2:0] d);
    return 7'((8'h01 << d) - 8'h01);
  endfunction : half_term
endpackage : scd_pkg

/* scd_clk_gen.sv */
// Glitch-free source switch and power-of-two divider
`timescale 1ns/1ps
`default_nettype none
module scd_clk_gen (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [4:0] src_lvl_i,
  input wire logic [2:0] sel_i,
  input wire logic [2:0] div_i,
  output logic sysclk_o,
  output logic [2:0] active_sel_o,
  output logic [2:0] applied_div_o,
  output logic src_edge_o
);
  logic [2:0] cur_sel_q, cur_sel_d;
  logic [2:0] app_div_q, app_div_d;
  logic prev_q, prev_d;
  logic out_q, out_d;
  logic [6:0] cnt_q, cnt_d;
  logic cur_lvl;
  logic edge_seen;

  always_comb begin
    cur_lvl = src_lvl_i[cur_sel_q];
    edge_seen = ce_i && (cur_lvl != prev_q);
    cur_sel_d = cur_sel_q;
    app_div_d = app_div_q;
    prev_d = prev_q;
    out_d = out_q;
    cnt_d = cnt_q;
    if (edge_seen) begin
      prev_d = cur_lvl;
      if (cnt_q == scd_pkg::half_term(app_div_q)) begin
        cnt_d = 7'h00;
        out_d = ~out_q;
        // New divide only at the end of a full low-going period
        if (out_q) begin
          app_div_d = div_i;
        end
      end else begin
        cnt_d = cnt_q + 7'h01;
      end
    end else if (!out_q && cnt_q == 7'h00 && sel_i != cur_sel_q &&
                 scd_pkg::sel_valid(sel_i) && !src_lvl_i[sel_i]) begin
      // Swap only while output and new source are both low
      cur_sel_d = sel_i;
      prev_d = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cur_sel_q <= scd_pkg::SEL_RESET;
      app_div_q <= scd_pkg::APPLIED_DIV_RESET;
      prev_q <= 1'b0;
      out_q <= 1'b0;
      cnt_q <= 7'h00;
    end else if (ce_i) begin
      cur_sel_q <= cur_sel_d;
      app_div_q <= app_div_d;
      prev_q <= prev_d;
      out_q <= out_d;
      cnt_q <= cnt_d;
    end
  end

  assign sysclk_o = out_q;
  assign active_sel_o = cur_sel_q;
  assign applied_div_o = app_div_q;
  assign src_edge_o = edge_seen;
endmodule : scd_clk_gen
`default_nettype wire

/* scd_clock_select.sv */
// System clock select, divider and precision oscillator control registers
// Behaviour
// - Divide field divides source by two to the field value, 1..128.
// - Divide change completes within 128 undivided source cycles.
// - Bit 7 reads 0 until new divide applies, then 1.
// - Source may change while running; takes one slower-clock period. Swap here waits for output and new source both low.
// - Source codes 0..4 pick the five oscillators; others reserved.
// - Select register bit 3 reads zero; software writes zero.
// - Oscillator control bit 7 enables the precision oscillator.
// - Bit 6 reads 1 only while precision oscillator is at frequency.
`timescale 1ns/1ps
`default_nettype none
module scd_clock_select (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic ce_i,
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic sfr_wr_i,
  input wire logic sfr_rd_i,
  output logic [7:0] sfr_rdata_o,
  input wire logic [4:0] osc_level_i,
  input wire logic precision_osc_stable_i,
  output logic precision_osc_enable_o,
  output logic sysclk_o,
  output logic [2:0] active_sel_o
);
  logic [2:0] div_q, div_d;
  logic [2:0] sel_q, sel_d;
  logic en_q, en_d;
  logic [5:0] rsvd_q, rsvd_d;
  logic [7:0] rdata_q, rdata_d;
  logic [2:0] applied_div;
  logic src_edge;
  logic divider_applied_flag;
  logic precision_osc_freq_ready;
  logic wr_sel, wr_osc, rd_sel, rd_osc;

  scd_clk_gen u_gen (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .src_lvl_i(osc_level_i),
    .sel_i(sel_q),
    .div_i(div_q),
    .sysclk_o(sysclk_o),
    .active_sel_o(active_sel_o),
    .applied_div_o(applied_div),
    .src_edge_o(src_edge)
  );

  assign divider_applied_flag = (applied_div == div_q);
  assign precision_osc_freq_ready = en_q && precision_osc_stable_i;
  assign precision_osc_enable_o = en_q;

  always_comb begin
    wr_sel = ce_i && sfr_wr_i && sfr_addr_i == scd_pkg::CLK_SELECT_ADDR;
    wr_osc = ce_i && sfr_wr_i && sfr_addr_i == scd_pkg::OSC_CONTROL_ADDR;
    rd_sel = ce_i && sfr_rd_i && sfr_addr_i == scd_pkg::CLK_SELECT_ADDR;
    rd_osc = ce_i && sfr_rd_i && sfr_addr_i == scd_pkg::OSC_CONTROL_ADDR;
    div_d = div_q;
    sel_d = sel_q;
    en_d = en_q;
    rsvd_d = rsvd_q;
    rdata_d = rdata_q;
    if (wr_sel) begin
      div_d = sfr_wdata_i[scd_pkg::DIV_LSB +: 3];
      // Reserved codes are stored but never switched to
      sel_d = sfr_wdata_i[scd_pkg::SEL_LSB +: 3];
    end
    if (wr_osc) begin
      en_d = sfr_wdata_i[scd_pkg::EN_BIT];
      rsvd_d = sfr_wdata_i[5:0];
    end
    if (ce_i && sfr_rd_i) begin
      rdata_d = 8'h00;
      if (rd_sel) begin
        rdata_d[scd_pkg::RDY_BIT] = divider_applied_flag;
        rdata_d[scd_pkg::DIV_LSB +: 3] = div_q;
        rdata_d[scd_pkg::UNUSED_BIT] = 1'b0;
        rdata_d[scd_pkg::SEL_LSB +: 3] = sel_q;
      end else if (rd_osc) begin
        rdata_d[scd_pkg::EN_BIT] = en_q;
        rdata_d[scd_pkg::FRDY_BIT] = precision_osc_freq_ready;
        rdata_d[5:0] = rsvd_q;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      div_q <= scd_pkg::DIV_RESET;
      sel_q <= scd_pkg::SEL_RESET;
      en_q <= scd_pkg::EN_RESET;
      rsvd_q <= scd_pkg::OSC_RSVD_RESET;
      rdata_q <= scd_pkg::RDATA_RESET;
    end else if (ce_i) begin
      div_q <= div_d;
      sel_q <= sel_d;
      en_q <= en_d;
      rsvd_q <= rsvd_d;
      rdata_q <= rdata_d;
    end
  end

  assign sfr_rdata_o = rdata_q;

  // Source edges spent waiting for a divide change
  logic [8:0] wait_edges_q;
  always_ff @(posedge clk_i) begin
    if (rst_i || divider_applied_flag) begin
      wait_edges_q <= 9'h000;
    end else if (src_edge && wait_edges_q != 9'h1ff) begin
      wait_edges_q <= wait_edges_q + 9'h001;
    end
  end

  a_div_bound: assert property (@(posedge clk_i) disable iff (rst_i)
    wait_edges_q <= scd_pkg::MAX_DIV_SRC_EDGES)
    else $error("divide change took more than 128 source cycles");

  a_ready_drops: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_sel && sfr_wdata_i[scd_pkg::DIV_LSB +: 3] != applied_div &&
    sfr_wdata_i[scd_pkg::DIV_LSB +: 3] != div_q
    |=> !divider_applied_flag)
    else $error("ready flag high before new divide applied");

  a_bit3_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_sel |=> !sfr_rdata_o[3])
    else $error("select register bit 3 read nonzero");

  a_enable_follow: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wr_osc |=> precision_osc_enable_o == $past(sfr_wdata_i[scd_pkg::EN_BIT]))
    else $error("oscillator enable not taken from write");

  a_freq_ready: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_osc && !(en_q && precision_osc_stable_i) |=> !sfr_rdata_o[6])
    else $error("frequency ready read high while not running");

  a_valid_source: assert property (@(posedge clk_i)
    disable iff (rst_i)
    active_sel_o <= scd_pkg::SRC_LOW_POWER)
    else $error("reserved source code became active");

  a_clk_on_edge: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(sysclk_o) |-> $past(src_edge))
    else $error("system clock changed without a source edge");

  a_div1_follow: assert property (@(posedge clk_i) disable iff (rst_i)
    src_edge && applied_div == 3'h0
    |=> sysclk_o == $past(osc_level_i[active_sel_o]))
    else $error("divide by one output does not follow source");

  a_switch_low: assert property (@(posedge clk_i) disable iff (rst_i)
    $changed(active_sel_o) |-> !sysclk_o && active_sel_o == $past(sel_q))
    else $error("source switched while clock high or to wrong code");

  a_rdata_other: assert property (@(posedge clk_i)
    disable iff (rst_i)
    ce_i && sfr_rd_i && !rd_sel && !rd_osc |=> sfr_rdata_o == 8'h00)
    else $error("unmapped read returned nonzero data");

  a_rdata_hold: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !(ce_i && sfr_rd_i) |=> $stable(sfr_rdata_o))
    else $error("read data changed without a read");

  a_freeze_ce: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !ce_i |=> $stable(div_q) && $stable(sel_q) && $stable(en_q) &&
    $stable(sysclk_o) && $stable(active_sel_o) && $stable(applied_div))
    else $error("state moved while clock enable low");

  a_div_write: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wr_sel |=> div_q == $past(sfr_wdata_i[scd_pkg::DIV_LSB +: 3]))
    else $error("divide field not taken from write");

  a_sel_write: assert property (@(posedge clk_i)
    disable iff (rst_i)
    wr_sel |=> sel_q == $past(sfr_wdata_i[scd_pkg::SEL_LSB +: 3]))
    else $error("source field not taken from write");

  a_reg_keep: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !wr_sel |=> $stable(div_q) && $stable(sel_q))
    else $error("select register changed without a write");

  a_sel_read: assert property (@(posedge clk_i)
    disable iff (rst_i)
    rd_sel |=> sfr_rdata_o[scd_pkg::SEL_LSB +: 3] == $past(sel_q) &&
    sfr_rdata_o[scd_pkg::DIV_LSB +: 3] == $past(div_q))
    else $error("select register read wrong fields");

  a_ready_read: assert property (@(posedge clk_i)
    disable iff (rst_i)
    rd_sel |=> sfr_rdata_o[scd_pkg::RDY_BIT] == $past(applied_div == div_q))
    else $error("ready flag read does not match applied divide");

  a_osc_read: assert property (@(posedge clk_i)
    disable iff (rst_i)
    rd_osc |=> sfr_rdata_o[scd_pkg::EN_BIT] == $past(en_q))
    else $error("enable bit read does not match register");

  a_enable_hold: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !wr_osc |=> $stable(precision_osc_enable_o))
    else $error("oscillator enable changed without a write");

  a_freq_ready_set: assert property (@(posedge clk_i)
    disable iff (rst_i)
    rd_osc && en_q && precision_osc_stable_i
    |=> sfr_rdata_o[scd_pkg::FRDY_BIT])
    else $error("frequency ready read low while running");

  a_ready_holds: assert property (@(posedge clk_i)
    disable iff (rst_i)
    divider_applied_flag && !wr_sel |=> divider_applied_flag)
    else $error("ready flag dropped without a divide write");

  a_div_on_fall: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $changed(applied_div) |-> $fell(sysclk_o))
    else $error("divide applied other than at a falling edge");

  a_div_from_prog: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $changed(applied_div) |-> applied_div == $past(div_q))
    else $error("applied divide differs from programmed value");

  a_switch_src_low: assert property (@(posedge clk_i)
    disable iff (rst_i)
    $changed(active_sel_o) |-> !$past(osc_level_i[sel_q]))
    else $error("source switched while new source high");
endmodule : scd_clock_select
`default_nettype wire

/* scd_clock_select_tb.sv */
// Self-checking bench for the clock select and divider block
`timescale 1ns/1ps
`default_nettype none
module scd_clock_select_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic [7:0] sfr_addr_i = 8'h00;
  logic [7:0] sfr_wdata_i = 8'h00;
  logic sfr_wr_i = 1'b0;
  logic sfr_rd_i = 1'b0;
  logic [4:0] osc_level_i = 5'h00;
  logic precision_osc_stable_i = 1'b0;
  logic [7:0] sfr_rdata_o;
  logic precision_osc_enable_o;
  logic sysclk_o;
  logic [2:0] active_sel_o;
  logic [7:0] rd_q;
  logic [3:0] ph_q = 4'h0;
  int bad_count = 0;
  int checked = 0;
  int cycles = 0;
  int n;

  always #12.5 clk_i = ~clk_i;

  scd_clock_select u_scd_clock_select (.clk_i(clk_i), .rst_i(rst_i),
    .ce_i(ce_i), .sfr_addr_i(sfr_addr_i), .sfr_wdata_i(sfr_wdata_i),
    .sfr_wr_i(sfr_wr_i), .sfr_rd_i(sfr_rd_i), .sfr_rdata_o(sfr_rdata_o),
    .osc_level_i(osc_level_i),
    .precision_osc_stable_i(precision_osc_stable_i),
    .precision_osc_enable_o(precision_osc_enable_o),
    .sysclk_o(sysclk_o), .active_sel_o(active_sel_o));

  // Sources 0..3 change every 2 cycles, source 4 every 4 cycles
  always @(negedge clk_i) begin
    ph_q <= ph_q + 4'h1;
    osc_level_i <= {ph_q[2], {4{ph_q[1]}}};
  end

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      bad_count++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    if (bad_count == 0 && checked > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : give_verdict

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp,
                      input logic [7:0] mask);
    checked++;
    if ((got & mask) !== (exp & mask)) begin
      bad_count++;
      $display("BAD %0t data %h expected %h", $time, got, exp);
    end
  endtask : cmp8

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_wdata_i = d;
    sfr_wr_i = 1'b1;
    @(negedge clk_i);
    sfr_wr_i = 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] a);
    @(negedge clk_i);
    sfr_addr_i = a;
    sfr_rd_i = 1'b1;
    @(negedge clk_i);
    sfr_rd_i = 1'b0;
    @(negedge clk_i);
    rd_q = sfr_rdata_o;
  endtask : rd

  // Rise-to-rise length of the system clock in bench cycles
  task automatic period(input int exp);
    int k;
    k = 0;
    while (sysclk_o !== 1'b0 && k < 600) begin
      @(negedge clk_i);
      k++;
    end
    while (sysclk_o !== 1'b1 && k < 1200) begin
      @(negedge clk_i);
      k++;
    end
    k = 0;
    while (sysclk_o !== 1'b0 && k < 600) begin
      @(negedge clk_i);
      k++;
    end
    while (sysclk_o !== 1'b1 && k < 600) begin
      @(negedge clk_i);
      k++;
    end
    checked++;
    if (k != exp) begin
      bad_count++;
      $display("BAD %0t period %0d expected %0d", $time, k, exp);
    end
  endtask : period

  initial begin
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    rd(scd_pkg::CLK_SELECT_ADDR);
    cmp8(rd_q, 8'h12, 8'h7f);
    cmp8({5'h00, active_sel_o}, 8'h02, 8'hff);
    rd(scd_pkg::OSC_CONTROL_ADDR);
    cmp8(rd_q, 8'h00, 8'hff);
    rd(8'ha8);
    cmp8(rd_q, 8'h00, 8'hff);
    precision_osc_stable_i = 1'b1;
    rd(scd_pkg::OSC_CONTROL_ADDR);
    cmp8(rd_q, 8'h00, 8'hff);
    // Bias taken as already on outside this block
    wr(scd_pkg::OSC_CONTROL_ADDR, {1'b1, rd_q[6:0]});
    cmp8({7'h00, precision_osc_enable_o}, 8'h01, 8'hff);
    rd(scd_pkg::OSC_CONTROL_ADDR);
    cmp8(rd_q, 8'hc0, 8'hff);
    precision_osc_stable_i = 1'b0;
    rd(scd_pkg::OSC_CONTROL_ADDR);
    cmp8(rd_q, 8'h80, 8'hff);
    precision_osc_stable_i = 1'b1;
    rd(scd_pkg::OSC_CONTROL_ADDR);
    cmp8(rd_q, 8'hc0, 8'hff);
    wr(scd_pkg::OSC_CONTROL_ADDR, {1'b0, rd_q[6:0]});
    rd(scd_pkg::OSC_CONTROL_ADDR);
    cmp8(rd_q, 8'h00, 8'hff);
    ce_i = 1'b0;
    wr(scd_pkg::CLK_SELECT_ADDR, 8'h74);
    ce_i = 1'b1;
    rd(scd_pkg::CLK_SELECT_ADDR);
    cmp8(rd_q, 8'h12, 8'h7f);
    for (int d = 0; d < 8; d++) begin
      wr(scd_pkg::CLK_SELECT_ADDR, {1'b0, 3'(d), 4'ha});
      rd(scd_pkg::CLK_SELECT_ADDR);
      cmp8(rd_q, {1'b0, 3'(d), 4'h2}, (d > 2) ? 8'hff : 8'h7f);
      n = 0;
      do begin
        rd(scd_pkg::CLK_SELECT_ADDR);
        n++;
      end while (rd_q[7] !== 1'b1 && n < 180);
      cmp8(rd_q, 8'h80, 8'h80);
      period(4 << d);
    end
    wr(scd_pkg::CLK_SELECT_ADDR, 8'h04);
    n = 0;
    while (active_sel_o !== 3'h4 && n < 700) begin
      @(negedge clk_i);
      n++;
    end
    cmp8({5'h00, active_sel_o}, 8'h04, 8'hff);
    period(8);
    wr(scd_pkg::CLK_SELECT_ADDR, 8'h05);
    rd(scd_pkg::CLK_SELECT_ADDR);
    cmp8(rd_q, 8'h05, 8'h7f);
    repeat (40) @(negedge clk_i);
    cmp8({5'h00, active_sel_o}, 8'h04, 8'hff);
    for (int s = 0; s < 4; s++) begin
      wr(scd_pkg::CLK_SELECT_ADDR, {5'h00, 3'(s)});
      n = 0;
      while (active_sel_o !== 3'(s) && n < 100) begin
        @(negedge clk_i);
        n++;
      end
      cmp8({5'h00, active_sel_o}, {5'h00, 3'(s)}, 8'hff);
    end
    give_verdict();
  end
endmodule : scd_clock_select_tb
`default_nettype wire
